// ---- pcc_detect_model.sv ----
// stand-in for the detect and class engine answering cycle_start
`timescale 1ns/1ps
`default_nettype none

module pcc_detect_model #(
	parameter int DLY = 3
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] cycle_start,
	input wire logic res_valid,
	input wire logic [3:0] res_cls,
	output var pcc_pkg::pcc_result_t [3:0] result
);
	logic [DLY-1:0][3:0] pipe;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pipe <= '0;
		end else begin
			pipe <= {pipe[DLY-2:0], cycle_start};
		end
	end
	// qualifiers invert outside done so they never match the live result
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			result[i].done = pipe[DLY-1][i];
			result[i].valid = pipe[DLY-1][i] ? res_valid : !res_valid;
			result[i].classification_phase = pipe[DLY-1][i] ? res_cls : ~res_cls;
		end
	end
endmodule // pcc_detect_model

`default_nettype wire

// ---- pcc_pkg.sv ----
// constants and types shared by the channel power command block
`default_nettype none

package pcc_pkg;

	// channel count served by one request byte
	localparam int NUM_CH = 4;

	// request byte: power-off bits above the power-on bits
	localparam int REQ_ON_LSB = 0;
	localparam int REQ_OFF_LSB = 4;
	localparam int REQ_W = 8;

	// class and allocation code widths
	localparam int CLASS_W = 4;
	localparam logic [3:0] CLASS_4PAIR_MIN = 4'h5;

	// power fault code values
	localparam int FAULT_W = 4;
	localparam logic [3:0] PF_NONE = 4'h0;
	// arbitrary value, the encoding is not given
	localparam logic [3:0] PF_INSUFFICIENT = 4'h1;

	// policing threshold restored on power-off
	localparam logic [7:0] POLICE_RESET = 8'hff;

	typedef enum logic [1:0] {
		PCC_MODE_OFF,
		PCC_MODE_MANUAL,
		PCC_MODE_SEMI,
		PCC_MODE_AUTO
	} pcc_mode_t;

	typedef enum logic [1:0] {
		PCC_CH_IDLE,
		PCC_CH_WAIT_OWN,
		PCC_CH_WAIT_SEMI,
		PCC_CH_ON
	} pcc_ch_state_t;

	// outcome of one detection and classification cycle
	typedef struct packed {
		logic done;
		logic valid;
		logic [3:0] classification_phase;
	} pcc_result_t;

	// one-cycle clear strobes sent to the channel's register owners
	typedef struct packed {
		logic status;
		logic police;
		logic meas;
		logic class_info;
	} pcc_clear_t;

endpackage

`default_nettype wire

// ---- pcc_power_command.sv ----
// per-channel power-on and power-off command interpreter
`timescale 1ns/1ps
`default_nettype none

module pcc_power_command #(
	parameter int NUM_CH = pcc_pkg::NUM_CH,
	parameter logic [3:0] FAULT_INSUFFICIENT = pcc_pkg::PF_INSUFFICIENT
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_wr,
	input wire logic [2*NUM_CH-1:0] req_data,
	input wire pcc_pkg::pcc_mode_t mode,
	input wire logic [NUM_CH/2-1:0] four_pair,
	input wire logic [NUM_CH/2-1:0] dual_sig,
	input wire logic [NUM_CH-1:0] detect_cycle_enable,
	input wire logic [NUM_CH-1:0] class_enable,
	input wire logic [NUM_CH-1:0] cooldown,
	input wire pcc_pkg::pcc_result_t [NUM_CH-1:0] result,
	input wire logic [NUM_CH-1:0][3:0] assigned_class,
	input wire logic [NUM_CH-1:0][3:0] alloc_class,
	output logic [NUM_CH-1:0] power_enabled_flag,
	output logic [NUM_CH-1:0] startup_fault_flag,
	output logic [NUM_CH-1:0][3:0] power_fault_code,
	output logic [NUM_CH-1:0] cycle_start,
	output pcc_pkg::pcc_clear_t [NUM_CH-1:0] chan_clear,
	output logic [7:0] police_restore_value
);

	// channels pair up into 4-pair ports, so the count must be even
	if (NUM_CH < 2 || NUM_CH % 2 != 0
		|| NUM_CH > pcc_pkg::NUM_CH) begin : g_chk
		$error("pcc_power_command: NUM_CH must be even, 2 to 4");
	end

	// allocation is enough when the class does not exceed the allowed class
	function automatic logic alloc_fit(input logic [3:0] classification_phase,
		input logic [3:0] limit);
		alloc_fit = (classification_phase <= limit);
	endfunction

	function automatic logic high_class(input logic [3:0] classification_phase);
		high_class = (classification_phase >= pcc_pkg::CLASS_4PAIR_MIN);
	endfunction

	pcc_pkg::pcc_ch_state_t state [NUM_CH];
	pcc_pkg::pcc_ch_state_t next_state [NUM_CH];
	logic [NUM_CH-1:0][3:0] alloc_lat;
	logic [NUM_CH-1:0][3:0] next_alloc_lat;
	logic [NUM_CH-1:0] next_fault;
	logic [NUM_CH-1:0][3:0] next_code;
	logic [NUM_CH-1:0] next_cycle_start;

	wire mode_active = (mode != pcc_pkg::PCC_MODE_OFF);
	wire mode_manual = (mode == pcc_pkg::PCC_MODE_MANUAL);
	wire mode_semi = (mode == pcc_pkg::PCC_MODE_SEMI);
	wire mode_auto = (mode == pcc_pkg::PCC_MODE_AUTO);

	logic [NUM_CH-1:0] on_bit;
	logic [NUM_CH-1:0] off_bit;
	logic [NUM_CH-1:0] on_req;
	logic [NUM_CH-1:0] off_req;
	logic [NUM_CH-1:0] fp;
	logic [NUM_CH-1:0] dual;
	logic [NUM_CH-1:0] both_en;
	logic [NUM_CH-1:0] pending;
	logic [NUM_CH-1:0] is_on;
	logic [NUM_CH-1:0] partner_on;
	logic [NUM_CH-1:0] partner_want;
	logic [NUM_CH-1:0] lone;
	logic [NUM_CH-1:0] partner_fit;
	logic [NUM_CH-1:0] cycle_ok;
	logic [NUM_CH-1:0] big_single;
	logic [NUM_CH-1:0] pair_grant;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_dec
		localparam int P = g ^ 1;
		// request bits only exist for the write strobe's cycle
		assign on_bit[g] = req_wr & req_data[pcc_pkg::REQ_ON_LSB + g];
		assign off_bit[g] = req_wr & req_data[pcc_pkg::REQ_OFF_LSB + g];
		assign off_req[g] = off_bit[g] & mode_active;
		// off beats on, and cool-down swallows the on request
		assign on_req[g] = on_bit[g] & ~off_bit[g] & mode_active
			& ~cooldown[g];
		assign fp[g] = four_pair[g/2];
		assign dual[g] = dual_sig[g/2];
		assign both_en[g] = detect_cycle_enable[g] & class_enable[g];
		assign pending[g] = (state[g] == pcc_pkg::PCC_CH_WAIT_OWN)
			| (state[g] == pcc_pkg::PCC_CH_WAIT_SEMI);
		assign is_on[g] = (state[g] == pcc_pkg::PCC_CH_ON);
		assign partner_on[g] = fp[g] & is_on[P];
		assign partner_want[g] = fp[g] & (on_req[P] | pending[P] | is_on[P]);
		// lone request on a 4-pair port, partner not asked in this write
		assign lone[g] = fp[g] & ~on_req[P];
		assign partner_fit[g] = alloc_fit(assigned_class[P], alloc_class[g]);
		assign cycle_ok[g] = result[g].done & result[g].valid;
		assign big_single[g] = fp[g] & ~dual[g] & high_class(result[g].classification_phase);
		// a high-class single-signature load powers both channels together
		assign pair_grant[g] = pending[g] & cycle_ok[g] & big_single[g]
			& partner_want[g] & alloc_fit(result[g].classification_phase, alloc_lat[g]);
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_state[i] = state[i];
			next_alloc_lat[i] = alloc_lat[i];
			next_fault[i] = startup_fault_flag[i];
			next_code[i] = power_fault_code[i];
			next_cycle_start[i] = 1'b0;
			if (off_req[i] || !mode_active) begin
				if (off_req[i]) begin
					// off clears the fault even if a result lands now
					next_fault[i] = 1'b0;
					next_code[i] = pcc_pkg::PF_NONE;
				end
				next_state[i] = pcc_pkg::PCC_CH_IDLE;
			end else if (cooldown[i]) begin
				next_state[i] = pcc_pkg::PCC_CH_IDLE;
			end else if (pair_grant[i ^ 1] && fp[i]
				&& state[i] != pcc_pkg::PCC_CH_ON) begin
				next_state[i] = pcc_pkg::PCC_CH_ON;
			end else begin
				case (state[i])
					pcc_pkg::PCC_CH_IDLE: begin
						if (on_req[i]) begin
							// allocation is frozen at the request
							next_alloc_lat[i] = alloc_class[i];
							if (mode_manual) begin
								next_state[i] = pcc_pkg::PCC_CH_ON;
							end else if (partner_on[i] && !dual[i]) begin
								next_state[i] = pcc_pkg::PCC_CH_ON;
							end else if (partner_on[i]) begin
								if (partner_fit[i]) begin
									next_state[i] = pcc_pkg::PCC_CH_ON;
								end
							end else if (mode_auto && lone[i]) begin
								next_state[i] = pcc_pkg::PCC_CH_IDLE;
							end else if (both_en[i] && mode_semi) begin
								// ride the running cycle, add none
								next_state[i] = pcc_pkg::PCC_CH_WAIT_SEMI;
							end else if (both_en[i] && mode_auto) begin
								next_state[i] = pcc_pkg::PCC_CH_IDLE;
							end else begin
								next_state[i] = pcc_pkg::PCC_CH_WAIT_OWN;
								next_cycle_start[i] = 1'b1;
							end
						end else if (mode_auto && both_en[i] && cycle_ok[i]) begin
							// unprompted attempt after every valid cycle
							if (big_single[i]) begin
								if (is_on[i ^ 1] || both_en[i ^ 1]) begin
									if (alloc_fit(result[i].classification_phase, alloc_class[i])) begin
										next_state[i] = pcc_pkg::PCC_CH_ON;
									end
								end
							end else if (alloc_fit(result[i].classification_phase, alloc_class[i])) begin
								next_state[i] = pcc_pkg::PCC_CH_ON;
							end
						end
					end
					pcc_pkg::PCC_CH_WAIT_OWN,
					pcc_pkg::PCC_CH_WAIT_SEMI: begin
						if (result[i].done) begin
							if (!result[i].valid) begin
								// no retry; semi cycling carries on outside
								next_state[i] = pcc_pkg::PCC_CH_IDLE;
							end else if (big_single[i]) begin
								if (pair_grant[i]) begin
									next_state[i] = pcc_pkg::PCC_CH_ON;
								end else begin
									next_state[i] = pcc_pkg::PCC_CH_IDLE;
									next_fault[i] = 1'b1;
									next_code[i] = FAULT_INSUFFICIENT;
								end
							end else if (alloc_fit(result[i].classification_phase, alloc_lat[i])) begin
								// only the requested channel comes up
								next_state[i] = pcc_pkg::PCC_CH_ON;
							end else begin
								next_state[i] = pcc_pkg::PCC_CH_IDLE;
							end
						end
					end
					pcc_pkg::PCC_CH_ON: begin
						next_state[i] = pcc_pkg::PCC_CH_ON;
					end
					default: begin
						next_state[i] = pcc_pkg::PCC_CH_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst) begin
				state[i] <= pcc_pkg::PCC_CH_IDLE;
			end else begin
				state[i] <= next_state[i];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alloc_lat <= '0;
			startup_fault_flag <= '0;
			power_fault_code <= '0;
			cycle_start <= '0;
		end else begin
			alloc_lat <= next_alloc_lat;
			startup_fault_flag <= next_fault;
			power_fault_code <= next_code;
			cycle_start <= next_cycle_start;
		end
	end

	// enable follows the state as registered, dropping the cycle after off
	always_ff @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst) begin
				power_enabled_flag[i] <= 1'b0;
			end else begin
				power_enabled_flag[i] <= (next_state[i] == pcc_pkg::PCC_CH_ON);
			end
		end
	end

	// one clear strobe per group; the owners of those registers act on it
	always_ff @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst) begin
				chan_clear[i] <= '0;
			end else begin
				chan_clear[i].status <= off_req[i];
				chan_clear[i].police <= off_req[i];
				chan_clear[i].meas <= off_req[i];
				chan_clear[i].class_info <= off_req[i];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			police_restore_value <= 8'h00;
		end else begin
			police_restore_value <= pcc_pkg::POLICE_RESET;
		end
	end

endmodule // pcc_power_command

`default_nettype wire

// ---- pcc_power_command_assertions.sv ----
// concurrent checks on channel 0 of the power command block
`timescale 1ns/1ps
`default_nettype none

module pcc_power_command_assertions #(
	parameter int NUM_CH = 4,
	parameter logic [3:0] FAULT_INSUFFICIENT = 4'h1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_wr,
	input wire logic [2*NUM_CH-1:0] req_data,
	input wire pcc_pkg::pcc_mode_t mode,
	input wire logic [NUM_CH-1:0] cooldown,
	input wire logic [NUM_CH-1:0] power_enabled_flag,
	input wire logic [NUM_CH-1:0] startup_fault_flag,
	input wire logic [NUM_CH-1:0][3:0] power_fault_code,
	input wire logic [NUM_CH-1:0] cycle_start,
	input wire pcc_pkg::pcc_clear_t [NUM_CH-1:0] chan_clear,
	input wire logic [7:0] police_restore_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic off0;
	wire logic on0;
	// mode off swallows both kinds of request
	assign off0 = req_wr && req_data[4] && mode != pcc_pkg::PCC_MODE_OFF;
	assign on0 = req_wr && req_data[0] && !req_data[4];

	a_off_clears_all: assert property (off0 |=> !power_enabled_flag[0]
		&& chan_clear[0] == 4'hf) else $error("off did not clear");
	a_off_clears_fault: assert property (off0 |=>
		!startup_fault_flag[0] && power_fault_code[0] == 4'h0)
		else $error("fault left after off");
	a_manual_turn_on: assert property (on0
		&& mode == pcc_pkg::PCC_MODE_MANUAL && !cooldown[0]
		&& !power_enabled_flag[0] |=> power_enabled_flag[0])
		else $error("manual on missed");
	a_mode_off_idle: assert property (
		(mode == pcc_pkg::PCC_MODE_OFF)[*2] |-> !power_enabled_flag[0])
		else $error("powered in off mode");
	a_cooldown_kept_off: assert property (cooldown[0][*2]
		|-> !power_enabled_flag[0]) else $error("powered in cooldown");
	a_start_has_cause: assert property (cycle_start[0]
		|-> $past(req_wr) && $past(req_data[0]))
		else $error("cycle start without request");
	a_fault_code_match: assert property (startup_fault_flag[0]
		|-> power_fault_code[0] == FAULT_INSUFFICIENT)
		else $error("fault code wrong");
	a_fault_stays_set: assert property (startup_fault_flag[0] && !off0
		|=> startup_fault_flag[0]) else $error("fault dropped");
	a_clear_single_pulse: assert property (chan_clear[0].status
		&& !off0 |=> !chan_clear[0].status) else $error("clear too long");
	a_police_all_ones: assert property (chan_clear[0].police
		|-> police_restore_value == pcc_pkg::POLICE_RESET)
		else $error("police value wrong");
endmodule // pcc_power_command_assertions

bind pcc_power_command pcc_power_command_assertions #(
	.NUM_CH(NUM_CH),
	.FAULT_INSUFFICIENT(FAULT_INSUFFICIENT)
) chk_u (
	.sys_clk(sys_clk),
	.rst(rst),
	.req_wr(req_wr),
	.req_data(req_data),
	.mode(mode),
	.cooldown(cooldown),
	.power_enabled_flag(power_enabled_flag),
	.startup_fault_flag(startup_fault_flag),
	.power_fault_code(power_fault_code),
	.cycle_start(cycle_start),
	.chan_clear(chan_clear),
	.police_restore_value(police_restore_value)
);

`default_nettype wire

// ---- pcc_power_command_bench.sv ----
// self-checking bench for the channel power command block
`timescale 1ns/1ps
`default_nettype none

module pcc_power_command_bench;
	logic sys_clk, rst, req_wr, res_valid;
	logic [7:0] req_data, prv;
	pcc_pkg::pcc_mode_t mode;
	logic [1:0] four_pair, dual_sig;
	logic [3:0] det_en, cls_en, cooldown, res_cls, pef, sff, cs;
	pcc_pkg::pcc_result_t [3:0] result;
	logic [3:0][3:0] asg_class, alloc_class, pfc;
	pcc_pkg::pcc_clear_t [3:0] cc;
	int err_count, total_checks;

	pcc_power_command dut_u (.sys_clk(sys_clk), .rst(rst), .req_wr(req_wr),
		.req_data(req_data), .mode(mode), .four_pair(four_pair),
		.dual_sig(dual_sig), .detect_cycle_enable(det_en),
		.class_enable(cls_en), .cooldown(cooldown), .result(result),
		.assigned_class(asg_class), .alloc_class(alloc_class),
		.power_enabled_flag(pef), .startup_fault_flag(sff),
		.power_fault_code(pfc), .cycle_start(cs), .chan_clear(cc),
		.police_restore_value(prv));
	pcc_detect_model model_u (.sys_clk(sys_clk), .rst(rst), .cycle_start(cs),
		.res_valid(res_valid), .res_cls(res_cls), .result(result));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one request write; returns just after the edge that took it
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk);
		req_wr <= 1'b1;
		req_data <= d;
		@(posedge sys_clk);
		req_wr <= 1'b0;
		#1;
	endtask

	task automatic wait_done(input int ch);
		int n;
		n = 0;
		while (result[ch].done !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 20) begin
				err_count++;
				$display("Error at %0t: no result", $time);
				wrap_up();
			end
		end
		@(posedge sys_clk);
		#1;
	endtask

	initial begin
		err_count = 0;
		total_checks = 0;
		rst = 1'b1;
		req_wr = 1'b0;
		req_data = 8'h00;
		mode = pcc_pkg::PCC_MODE_MANUAL;
		{four_pair, dual_sig} = 4'h0;
		{det_en, cls_en, cooldown} = 12'h000;
		{res_valid, res_cls} = 5'h00;
		asg_class = '0;
		alloc_class = {4{4'h4}};
		repeat (8) @(posedge sys_clk);
		#1;
		chk(pef, 4'h0);
		@(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(prv[7:4], 4'hf);
		chk(prv[3:0], 4'hf);
		wr(8'h03);
		chk(pef, 4'h3);
		wr(8'h00);
		chk(pef, 4'h3);
		wr(8'h11);
		chk(pef, 4'h2);
		chk(cc[0], 4'hf);
		chk(cc[1], 4'h0);
		@(posedge sys_clk);
		#1;
		chk(cc[0], 4'h0);
		cooldown = 4'h1;
		wr(8'h01);
		chk(pef, 4'h2);
		cooldown = 4'h0;
		mode = pcc_pkg::PCC_MODE_OFF;
		wr(8'h08);
		chk(pef, 4'h0);
		chk(cs, 4'h0);
		mode = pcc_pkg::PCC_MODE_SEMI;
		{res_valid, res_cls} = 5'h13;
		wr(8'h04);
		chk(cs, 4'h4);
		wait_done(2);
		chk(pef, 4'h4);
		res_valid = 1'b0;
		wr(8'h08);
		wait_done(3);
		chk(pef, 4'h4);
		repeat (3) @(posedge sys_clk);
		#1;
		chk(cs, 4'h0);
		four_pair = 2'b01;
		{res_valid, res_cls} = 5'h16;
		wr(8'h01);
		wait_done(0);
		chk(sff, 4'h1);
		chk(pfc[0], pcc_pkg::PF_INSUFFICIENT);
		chk(pef, 4'h4);
		wr(8'h10);
		chk(sff, 4'h0);
		chk(pfc[0], pcc_pkg::PF_NONE);
		alloc_class[1:0] = {4'h8, 4'h8};
		wr(8'h03);
		chk(cs, 4'h3);
		wait_done(0);
		chk(pef, 4'h7);
		wr(8'h33);
		chk(pef, 4'h4);
		mode = pcc_pkg::PCC_MODE_AUTO;
		det_en = 4'h8;
		wr(8'h01);
		chk(cs, 4'h0);
		res_cls = 4'h3;
		wr(8'h08);
		chk(cs, 4'h8);
		wait_done(3);
		chk(pef, 4'hc);
		mode = pcc_pkg::PCC_MODE_MANUAL;
		wr(8'h01);
		chk(pef, 4'hd);
		mode = pcc_pkg::PCC_MODE_SEMI;
		wr(8'h02);
		chk(pef, 4'hf);
		wr(8'h20);
		chk(pef, 4'hd);
		dual_sig = 2'b01;
		asg_class[0] = 4'h3;
		wr(8'h02);
		chk(pef, 4'hf);
		wr(8'h20);
		asg_class[0] = 4'h9;
		wr(8'h02);
		chk(pef, 4'hd);
		wrap_up();
	end
endmodule // pcc_power_command_bench

`default_nettype wire
